// ### rtl/eki_pkg.sv
// Constants, register map and carrier types of the external request and key-scan controller.
// Assumes one 100 MHz system clock and an AHB-Lite register bus with 32-bit data.
package eki_pkg;

  // Sizes
  localparam int NUM_LINES = 8;
  localparam int NUM_KEYS = 16;
  localparam int NUM_INTERNAL = 26;
  localparam int VEC_W = 6;

  // Register byte offsets
  localparam logic [7:0] OFF_LINE_EN = 8'h00;
  localparam logic [7:0] OFF_SENSE = 8'h04;
  localparam logic [7:0] OFF_KMASK_LO = 8'h08;
  localparam logic [7:0] OFF_KMASK_HI = 8'h0c;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // Reset values
  localparam logic [7:0] RST_LINE_EN = 8'h00;
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [7:0] RST_KMASK_LO = 8'hbf;
  localparam logic [7:0] RST_KMASK_HI = 8'hff;
  localparam logic RST_NMI_EDGE = 1'b0;

  // Field positions
  localparam int CTRL_NMI_EDGE_BIT = 0;
  localparam int STAT_PEND_LSB = 0;
  localparam int STAT_NMI_BIT = 8;
  localparam int STAT_LVL_LSB = 16;
  localparam int KEY_LINE = 6;

  // Sense and edge encodings
  localparam logic SENSE_LEVEL = 1'b0;
  localparam logic NMI_EDGE_RISE = 1'b1;

  // Vector numbers
  localparam logic [VEC_W-1:0] VEC_NONE = 6'h00;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h03;
  localparam logic [VEC_W-1:0] VEC_LINE0 = 6'h04;
  localparam logic [VEC_W-1:0] VEC_INT0 = 6'h0c;

  // Lines able to leave software standby
  localparam logic [7:0] WAKE_LINES = 8'h47;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Request toward the processor core
  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vector;
  } eki_req_t;

  // Active-low request pins
  typedef struct packed {
    logic nmi_n;
    logic [NUM_LINES-1:0] irq_n;
    logic [NUM_KEYS-1:0] key_n;
  } eki_pins_t;

endpackage

// ### rtl/eki_intc.sv
// Request side of the interrupt controller: pin sensing, key merge, pending state, arbiter.
// Assumes pins are asynchronous to clk and the core returns a one-cycle acknowledge per request.
// Operation
// (R1) Eight line enable bits, 0 disables, 1 enables, all reset to 0.
// (R2) Edge request seen while enabled latches pending until serviced.
// (R3) Disabling keeps a pending edge request but ignores new edges.
// (R4) Pending edge request is delivered after disable while mask flag is 0.
// (R5) Pending cleared when mask flag 1, sense bit 0, enable bit 0.
// (R6) Software discards pending by mask, disable, sense 0 then 1.
// (R7) Low key mask covers keys 7..0, high key mask keys 15..8.
// (R8) Key mask 0 passes the key, 1 blocks it.
// (R9) Key masks reset to 1 except low bit 6, which resets to 0.
// (R10) Line 6 is ORed with all sixteen unmasked key inputs.
// (R11) Software unmasks used keys and masks unused ones.
// (R12) Nonmaskable request on the selected edge regardless of mask flag.
// (R13) Nonmaskable vector is 3; its handling sets the mask flag.
// (R14) Each line sensed by low level or falling edge per its bit.
// (R15) Mask flag blocks all eight lines besides their own enables.
// (R16) Lines 0..7 use vectors 4..11, line 0 highest priority.
// (R17) Line detection works whatever the pin direction.
// (R18) Software sets used line pins as inputs and unshared.
// (R19) Nonmaskable input and lines 0, 1, 2, 6 wake from standby.
// (R20) Twenty-six internal requests use vectors 12 to 37.
// (R21) Mask flag blocks internal requests; acceptance sets the flag.
// (R22) Sense bit 0 requests while low, 1 on falling edge; reset 0.
// (R23) Edge select 0 falling, 1 rising for nonmaskable; reset 0.
// (R24) Only the highest priority accepted request and vector go out.
// (R25) Level requests are not latched; they follow the enabled low input.
// (R26) Edges compare synchronized samples; one fall gives one pending.
`timescale 1ns/1ns
`default_nettype none

module eki_intc #(
  parameter int NUM_INT = eki_pkg::NUM_INTERNAL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Request pins
  input wire eki_pkg::eki_pins_t pins_i,
  // Internal peripheral requests, already enabled at their source
  input wire logic [NUM_INT-1:0] int_req_i,
  // Processor core
  input wire logic mask_flag_i,
  input wire logic core_ack_i,
  output eki_pkg::eki_req_t req_o,
  // Standby
  input wire logic standby_i,
  output logic wake_o
);
  import eki_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Highest priority wins: later assignments in the loops override earlier ones
  function automatic eki_req_t pick(input logic nmi, input logic [NUM_LINES-1:0] lines,
                                    input logic [NUM_INT-1:0] ints);
    eki_req_t r;
    r.valid = 1'b0;
    r.vector = VEC_NONE;
    for (int i = NUM_INT - 1; i >= 0; i--) begin
      if (ints[i]) begin
        r.valid = 1'b1;
        r.vector = VEC_INT0 + VEC_W'(i); // [R20]
      end
    end
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (lines[i]) begin
        r.valid = 1'b1;
        r.vector = VEC_LINE0 + VEC_W'(i); // [R16]
      end
    end
    if (nmi) begin
      r.valid = 1'b1;
      r.vector = VEC_NMI; // [R13]
    end
    return r;
  endfunction

  // Pin synchronisers and glitch filter
  eki_pins_t s1_q, s2_q, s3_q, flt_q, flt_d;
  logic [NUM_LINES-1:0] low_prev_q, low_prev_d;
  logic nmi_prev_q, nmi_prev_d;

  // Registers
  logic [7:0] line_en_q, line_en_d;
  logic [7:0] sense_q, sense_d;
  logic [7:0] kmask_lo_q, kmask_lo_d;
  logic [7:0] kmask_hi_q, kmask_hi_d;
  logic nmi_edge_q, nmi_edge_d;

  // Pending and output state
  logic [NUM_LINES-1:0] pend_q, pend_d;
  logic nmi_pend_q, nmi_pend_d;
  eki_req_t req_q, req_d;
  logic wake_q, wake_d;

  // Bus state
  logic wr_pend_q, wr_pend_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] rdata_q, rdata_d;

  // Derived signals
  logic [NUM_KEYS-1:0] kmask;
  logic key_low;
  logic [NUM_LINES-1:0] line_low, line_fall, edge_set, pend_clr, line_req, line_acc;
  logic nmi_edge_hit;
  logic [NUM_INT-1:0] int_acc;
  logic addr_ok;

  // Pins have no direction control here, so output pins still request [R17]
  always_comb begin
    for (int b = 0; b < $bits(eki_pins_t); b++) begin
      flt_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : flt_q[b];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      flt_q <= '1;
      low_prev_q <= '0;
      nmi_prev_q <= 1'b1;
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
      low_prev_q <= low_prev_d;
      nmi_prev_q <= nmi_prev_d;
    end
  end

  // Key merge and edge detection
  always_comb begin
    kmask = {kmask_hi_q, kmask_lo_q}; // [R7]
    key_low = |(~flt_q.key_n & ~kmask); // [R8]
    line_low = ~flt_q.irq_n;
    line_low[KEY_LINE] = line_low[KEY_LINE] | key_low; // [R10]
    low_prev_d = line_low;
    line_fall = line_low & ~low_prev_q; // [R26]
    nmi_prev_d = flt_q.nmi_n;
    if (nmi_edge_q == NMI_EDGE_RISE) begin
      nmi_edge_hit = flt_q.nmi_n & ~nmi_prev_q; // [R23]
    end else begin
      nmi_edge_hit = ~flt_q.nmi_n & nmi_prev_q; // [R23]
    end
  end

  // Pending state and arbitration
  always_comb begin
    edge_set = line_fall & line_en_q & sense_q; // [R2] [R3]
    pend_clr = {NUM_LINES{mask_flag_i}} & ~sense_q & ~line_en_q; // [R5]
    // Ack clears only the vector presented at that edge
    for (int i = 0; i < NUM_LINES; i++) begin
      if (core_ack_i && req_q.valid && req_q.vector == VEC_LINE0 + VEC_W'(i)) begin
        pend_clr[i] = 1'b1; // [R2]
      end
      if (sense_q[i] == SENSE_LEVEL) begin
        line_req[i] = line_en_q[i] & line_low[i]; // [R25] [R22] [R1]
      end else begin
        line_req[i] = pend_q[i]; // [R4] [R14]
      end
    end
    // Set wins over clear
    pend_d = (pend_q & ~pend_clr) | edge_set;
    nmi_pend_d = nmi_pend_q;
    if (core_ack_i && req_q.valid && req_q.vector == VEC_NMI) begin
      nmi_pend_d = 1'b0;
    end
    if (nmi_edge_hit) begin
      nmi_pend_d = 1'b1; // [R12]
    end
    line_acc = line_req & {NUM_LINES{~mask_flag_i}}; // [R15]
    int_acc = int_req_i & {NUM_INT{~mask_flag_i}}; // [R21]
    req_d = pick(nmi_pend_q, line_acc, int_acc); // [R24]
    // Standby wake ignores the mask flag so a masked core can still be woken
    wake_d = standby_i & (nmi_pend_q | |(line_req & WAKE_LINES)); // [R19]
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= '0;
      nmi_pend_q <= 1'b0;
      req_q <= '0;
      wake_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      nmi_pend_q <= nmi_pend_d;
      req_q <= req_d;
      wake_q <= wake_d;
    end
  end

  // Register writes land in the data phase
  always_comb begin
    line_en_d = line_en_q;
    sense_d = sense_q;
    kmask_lo_d = kmask_lo_q;
    kmask_hi_d = kmask_hi_q;
    nmi_edge_d = nmi_edge_q;
    if (wr_pend_q) begin
      if (waddr_q == OFF_LINE_EN) begin
        line_en_d = hwdata[7:0]; // [R1]
      end else if (waddr_q == OFF_SENSE) begin
        sense_d = hwdata[7:0]; // [R14]
      end else if (waddr_q == OFF_KMASK_LO) begin
        kmask_lo_d = hwdata[7:0]; // [R7]
      end else if (waddr_q == OFF_KMASK_HI) begin
        kmask_hi_d = hwdata[7:0]; // [R7]
      end else if (waddr_q == OFF_CTRL) begin
        nmi_edge_d = hwdata[CTRL_NMI_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_en_q <= RST_LINE_EN; // [R1]
      sense_q <= RST_SENSE; // [R22]
      kmask_lo_q <= RST_KMASK_LO; // [R9]
      kmask_hi_q <= RST_KMASK_HI; // [R9]
      nmi_edge_q <= RST_NMI_EDGE; // [R23]
    end else begin
      line_en_q <= line_en_d;
      sense_q <= sense_d;
      kmask_lo_q <= kmask_lo_d;
      kmask_hi_q <= kmask_hi_d;
      nmi_edge_q <= nmi_edge_d;
    end
  end

  // Bus slave: zero wait states, reads see a write in the same cycle through the _d values
  always_comb begin
    wr_pend_d = 1'b0;
    waddr_d = waddr_q;
    rdata_d = rdata_q;
    addr_ok = (haddr[31:8] == '0);
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      waddr_d = addr_ok ? haddr[7:0] : 8'hff;
      wr_pend_d = hwrite;
      if (!hwrite) begin
        // Unmapped words read zero so stale data never leaks
        rdata_d = '0;
        if (!addr_ok) begin
          rdata_d = '0;
        end else if (haddr[7:0] == OFF_LINE_EN) begin
          rdata_d[7:0] = line_en_d;
        end else if (haddr[7:0] == OFF_SENSE) begin
          rdata_d[7:0] = sense_d;
        end else if (haddr[7:0] == OFF_KMASK_LO) begin
          rdata_d[7:0] = kmask_lo_d;
        end else if (haddr[7:0] == OFF_KMASK_HI) begin
          rdata_d[7:0] = kmask_hi_d;
        end else if (haddr[7:0] == OFF_CTRL) begin
          rdata_d[CTRL_NMI_EDGE_BIT] = nmi_edge_d;
        end else if (haddr[7:0] == OFF_STATUS) begin
          rdata_d[STAT_PEND_LSB +: NUM_LINES] = pend_q;
          rdata_d[STAT_NMI_BIT] = nmi_pend_q;
          rdata_d[STAT_LVL_LSB +: NUM_LINES] = line_low;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      waddr_q <= '0;
      rdata_q <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      waddr_q <= waddr_d;
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = rdata_q;
  assign req_o = req_q;
  assign wake_o = wake_q;

  // Checks
  a_nmi_vector_out: assert property ( // [R13]
    nmi_pend_q |=> req_q.valid && req_q.vector == VEC_NMI
  ) else $error("pending nonmaskable request not presented with vector 3");

  a_mask_blocks_all: assert property ( // [R15]
    (mask_flag_i && !nmi_pend_q) |=> !req_q.valid
  ) else $error("maskable request passed while mask flag set");

  a_edge_latches: assert property ( // [R2]
    (edge_set != '0) |=> ((pend_q & $past(edge_set)) == $past(edge_set))
  ) else $error("enabled falling edge not latched as pending");

  a_disabled_edge_ignored: assert property ( // [R3]
    ((line_fall & ~line_en_q & ~pend_q) != '0) |=> ((pend_q & $past(line_fall & ~line_en_q & ~pend_q)) == '0)
  ) else $error("edge on disabled line became pending");

  a_pending_cleared: assert property ( // [R5]
    (pend_clr != '0) |=> ((pend_q & $past(pend_clr & ~edge_set)) == '0)
  ) else $error("pending request survived clear condition");

  a_line0_priority: assert property ( // [R24]
    (!mask_flag_i && !nmi_pend_q && line_req[0]) |=> req_q.vector == VEC_LINE0
  ) else $error("line 0 did not win arbitration");

  a_disabled_pend_served: assert property ( // [R4]
    (!mask_flag_i && !nmi_pend_q && pend_q[1] && sense_q[1] && !line_en_q[1] && !line_req[0])
      |=> req_q.vector == VEC_LINE0 + VEC_W'(1)
  ) else $error("pending request of disabled line not delivered");

  a_key_merge: assert property ( // [R10]
    ((~flt_q.key_n & ~kmask) != '0 && line_en_q[KEY_LINE] && sense_q[KEY_LINE] == SENSE_LEVEL)
      |-> line_req[KEY_LINE]
  ) else $error("unmasked key input did not raise line 6");

  a_fall_once: assert property ( // [R26]
    (line_fall != '0) |=> ((line_fall & $past(line_fall)) == '0)
  ) else $error("one falling transition counted twice");

  a_nmi_edge_falls: assert property ( // [R23]
    (!nmi_edge_q && !flt_q.nmi_n && nmi_prev_q) |=> nmi_pend_q
  ) else $error("falling nonmaskable edge missed");

  a_level_follows_pin: assert property ( // [R25]
    (~sense_q & line_req & ~line_low) == '0
  ) else $error("level request stood without a low input");

  a_level_disabled: assert property ( // [R1]
    (~sense_q & line_req & ~line_en_q) == '0
  ) else $error("disabled level line raised a request");

  a_key_masked: assert property ( // [R8]
    ((flt_q.key_n | kmask) == '1) |-> !key_low
  ) else $error("masked or idle key inputs raised a key request");

  a_nmi_ack_clears: assert property ( // [R13]
    (core_ack_i && req_q.valid && req_q.vector == VEC_NMI && !nmi_edge_hit) |=> !nmi_pend_q
  ) else $error("accepted nonmaskable request stayed pending");

  a_internal_vector: assert property ( // [R20]
    (!mask_flag_i && !nmi_pend_q && line_req == '0 && int_req_i != '0)
      |=> (req_q.valid && req_q.vector >= VEC_INT0 && req_q.vector <= VEC_INT0 + VEC_W'(NUM_INT - 1))
  ) else $error("internal request presented outside vectors 12 to 37");

  a_wake_on_nmi: assert property ( // [R19]
    (standby_i && nmi_pend_q) |=> wake_q
  ) else $error("pending nonmaskable request did not wake from standby");

  c_nmi_taken: cover property (nmi_pend_q ##1 core_ack_i);
  c_level_request: cover property (line_req[0] && sense_q[0] == SENSE_LEVEL && !mask_flag_i);
  c_key_request: cover property (key_low && line_en_q[KEY_LINE] && !mask_flag_i);
  c_pend_discard: cover property (pend_q != '0 ##1 (pend_clr & $past(pend_q)) != '0);
  c_internal_wins: cover property (req_q.valid && req_q.vector >= VEC_INT0);

endmodule

`default_nettype wire

// ### verification/eki_core_model.sv
// Processor core model: takes the presented request, acknowledges it, masks.
// Assumes the controller's one-cycle acknowledge contract and registered req_o.
`timescale 1ns/1ns
`default_nettype none
module eki_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Controller side
  input wire eki_pkg::eki_req_t req,
  output logic ack,
  output logic mask_flag,
  // Bench controls
  input wire logic take,
  input wire logic unmask
);
  import eki_pkg::*;
  logic [2:0] busy_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      mask_flag <= 1'b1;
      busy_q <= 3'h0;
    end else begin
      // Gap after an ack, since req_o lags the pending clear by an edge
      ack <= take && req.valid && !ack && busy_q == 3'h0;
      if (ack)
        busy_q <= 3'h6;
      else if (busy_q != 3'h0)
        busy_q <= busy_q - 3'h1;
      // Acceptance masks all but the nonmaskable request
      mask_flag <= ack || busy_q != 3'h0 || !unmask;
    end
  end
endmodule
`default_nettype wire

// ### verification/external_irq_keyscan_intc_tb.sv
// Testbench of the request-side controller: bus tasks, pin stimulus, queue model.
// Assumes the package, the controller and the core model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module external_irq_keyscan_intc_tb;
  import eki_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  eki_pins_t pins = 25'h1ffffff; // Input-only, unshared request pins
  logic [NUM_INTERNAL-1:0] ints = 26'h0;
  logic take = 1'b0;
  logic unmask = 1'b0;
  logic standby = 1'b0;
  logic ack;
  logic mask;
  logic wake;
  eki_req_t rq;
  int num_errors = 0;
  int comparisons = 0;
  logic [6:0] got_q[$];
  logic [31:0] r;
  logic [7:0] r8;
  longint pend;
  int k;

  eki_intc dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .pins_i(pins), .int_req_i(ints), .mask_flag_i(mask), .core_ack_i(ack), .req_o(rq),
    .standby_i(standby), .wake_o(wake)
  );
  eki_core_model core (.clk(clk), .resetn(resetn), .req(rq), .ack(ack), .mask_flag(mask), .take(take),
    .unmask(unmask));

  always #5 clk = ~clk;
  // Every accepted vector, in order
  always @(posedge clk) if (ack === 1'b1 && rq.valid === 1'b1) got_q.push_back(rq);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_req(input logic [6:0] e);
    check({25'h0, rq}, {25'h0, e});
  endtask

  // One single transfer; called just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1)
      @(posedge clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(r, e);
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  // Pulses longer than the synchroniser needs
  task automatic pulse(input logic [7:0] m);
    pins.irq_n <= ~m;
    repeat (4) @(posedge clk);
    pins.irq_n <= 8'hff;
    settle();
  endtask

  // Expected winner: nonmaskable first, then bit 0 upward (lines, then internal)
  function automatic logic [6:0] win(input longint s, input bit n, input bit m);
    if (n)
      return {1'b1, VEC_NMI};
    for (int i = 0; i < 34; i++)
      if (!m && s[i])
        return {1'b1, VEC_LINE0 + 6'(i)};
    return 7'h0;
  endfunction

  // Let the core take requests, then compare the accepted order with the model
  task automatic serve(input longint s, input bit n, input bit m);
    logic [6:0] e;
    got_q = {};
    take <= 1'b1;
    unmask <= !m;
    repeat (100) @(posedge clk);
    take <= 1'b0;
    unmask <= 1'b0;
    repeat (10) @(posedge clk);
    do begin
      e = win(s, n, m);
      check({25'h0, (got_q.size() > 0 ? got_q.pop_front() : 7'h0)}, {25'h0, e});
      if (e == {1'b1, VEC_NMI})
        n = 1'b0;
      else if (e[6])
        s[e[5:0] - 4] = 1'b0;
    end while (e[6]);
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [31:0] rst_v[7];
    rst_v = '{32'h0, 32'h0, 32'hbf, 32'hff, 32'h0, 32'h0, 32'h0};
    void'($urandom(32'h796eec5c));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Reset values, then an unmapped word
    for (k = 0; k < 7; k++)
      rd(8'(4 * k), rst_v[k]);
    r8 = 8'($urandom());
    wr(OFF_KMASK_HI, r8);
    rd(OFF_KMASK_HI, {24'h0, r8});
    wr(8'h18, 8'h5a);
    rd(8'h18, 32'h0);
    wr(OFF_KMASK_HI, 8'hff);
    // Edge mode while masked
    wr(OFF_SENSE, 8'hff);
    wr(OFF_LINE_EN, 8'hff);
    pulse(r8);
    pend = longint'(r8);
    rd(OFF_STATUS, {24'h0, r8});
    chk_req(win(pend, 1'b0, 1'b1));
    wr(OFF_LINE_EN, 8'h0f);
    pulse(8'hff);
    pend = pend | 64'h0f;
    // Discard lines 6 and 7 by sense 0 then 1
    wr(OFF_SENSE, 8'h3f);
    wr(OFF_SENSE, 8'hff);
    pend = pend & 64'h3f;
    rd(OFF_STATUS, pend[31:0]);
    // Disable every line so all pending edges are served while disabled
    wr(OFF_LINE_EN, 8'h00);
    serve(pend, 1'b0, 1'b0);
    rd(OFF_STATUS, 32'h0);
    // Level mode
    wr(OFF_SENSE, 8'h00);
    wr(OFF_LINE_EN, 8'h41);
    unmask <= 1'b1;
    pins.irq_n[0] <= 1'b0;
    settle();
    chk_req(win(64'h1, 1'b0, 1'b0));
    pins.irq_n[0] <= 1'b1;
    settle();
    chk_req(7'h0);
    // One key through its mask into line 6
    k = $urandom_range(15);
    wr(OFF_KMASK_LO, 8'hff);
    pins.key_n[k] <= 1'b0;
    settle();
    chk_req(7'h0);
    if (k < 8)
      wr(OFF_KMASK_LO, ~(8'h1 << k));
    else
      wr(OFF_KMASK_HI, ~(8'h1 << (k - 8)));
    settle();
    chk_req(win(64'h40, 1'b0, 1'b0));
    pins.key_n[k] <= 1'b1;
    wr(OFF_KMASK_HI, 8'hff);
    wr(OFF_KMASK_LO, RST_KMASK_LO);
    // Internal source, open then masked
    k = $urandom_range(NUM_INTERNAL - 1);
    ints[k] <= 1'b1;
    settle();
    chk_req(win(64'h1 << (k + 8), 1'b0, 1'b0));
    unmask <= 1'b0;
    settle();
    chk_req(7'h0);
    ints[k] <= 1'b0;
    // Nonmaskable on either edge, in standby
    standby <= 1'b1;
    pins.nmi_n <= 1'b0;
    settle();
    check({31'h0, wake}, 32'h1);
    serve(64'h0, 1'b1, 1'b1);
    wr(OFF_CTRL, 8'h01);
    pins.nmi_n <= 1'b1;
    settle();
    serve(64'h0, 1'b1, 1'b1);
    pins.nmi_n <= 1'b0;
    settle();
    check({31'h0, wake}, 32'h0);
    rd(OFF_STATUS, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
